// ===== hw/swc_pkg.sv
// constants, option layout and types of the suspend and warm-up controller
package swc_pkg;

	localparam int CLK_HZ = 200_000_000;
	localparam int CK_HZ = 2_000_000;
	localparam int CK_DIV = CLK_HZ / CK_HZ;
	localparam int CK_DIV_W = 7;

	localparam int PWR_WARMUP_MS = 11;
	localparam int POR_WARMUP_CKS = PWR_WARMUP_MS * (CK_HZ / 1000);
	localparam int PD_RESET_WARMUP_CKS = 1000;
	localparam int IRQ_WAKE_WARMUP_CKS = 64;

	localparam int OSC_EXP_00 = 17;
	localparam int OSC_EXP_01 = 14;
	localparam int OSC_EXP_10 = 11;
	localparam int OSC_EXP_11 = 8;
	localparam int OSC_EXP_RC = 7;
	localparam int CNT_W = 18;

	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_SUSPEND_UNLOCK = 8'h8E;
	localparam logic [7:0] UNLOCK_KEY = 8'h55;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] SUSPEND_UNLOCK_RESET = 8'h00;

	localparam int PC_IDLE_BIT = 0;
	localparam int PC_PD_BIT = 1;
	localparam int PC_GF_LO = 2;
	localparam int PC_GF_HI = 3;
	localparam int PC_SERIAL_CTRL_FUNC_SEL_BIT = 6;
	localparam int PC_BAUD_DOUBLE_BIT = 7;

	localparam logic [3:0] CLK_SRC_RC12 = 4'h0;
	localparam logic [3:0] CLK_SRC_RC16 = 4'h1;
	localparam logic [3:0] CLK_SRC_XTAL = 4'hE;

	localparam logic [3:0] SYNC_RESET = 4'h1;

	typedef struct packed {
		logic [3:0] clock_source_option;
		logic osc_range_option;
		logic high_speed_option;
		logic reset_pin_option;
		logic lowvolt_reset_enable_option;
		logic lowvolt_level_option;
		logic watchdog_enable_option;
		logic watchdog_in_sleep_option;
		logic [1:0] warmup_length_option;
		logic overload_action_option;
		logic clock_monitor_warmup_option;
	} swc_option_t;

	localparam swc_option_t OPTION_DEFAULT = '{CLK_SRC_RC12, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
		1'b0, 1'b0, 2'h0, 1'b1, 1'b0};

	typedef struct packed {
		logic src_rc16;
		logic src_external;
		logic range_low;
		logic high_speed;
		logic reset_pin_is_reset;
		logic lowvolt_reset_enable;
		logic lowvolt_level_low;
		logic watchdog_enable;
		logic watchdog_in_sleep;
		logic [1:0] warmup_length;
		logic overload_irq_mode;
		logic monitor_off_in_warmup;
	} swc_config_t;

	typedef enum logic [2:0] {
		ST_PWR = 3'b000,
		ST_OSC = 3'b001,
		ST_RUN = 3'b010,
		ST_IDLE = 3'b011,
		ST_PDOWN = 3'b100
	} swc_state_t;

endpackage

// ===== hw/swc_suspend_warmup.sv
// suspend entry guard, warm-up sequencing and option decoding
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps

// Overview of operation
// - power-down bit set by software, hardware-cleared
// - idle bit set by software, hardware-cleared
// - broken unlock sequence clears unlock or request
// - both bits set: power-down, both cleared
// - two general flags, storage only
// - baud double and serial select passed out
// - both registers reset to zero on resets
// - oscillator warm-up on resets and power-down wake, except pin reset out of power-down
// - power warm-up precedes oscillator warm-up
// - power warm-up lengths per wake cause
// - power warm-up counted on 2MHz clock
// - oscillator warm-up length from option for external source only
// - options read during power warm-up
// - clock source option decode
// - range option gates high-speed option
// - reset pin option selects pin use
// - low-voltage reset enable and level
// - watchdog enable and sleep option
// - overload raises reset or interrupt
// - clock monitor suppressed in warm-up option
// - interrupt exit clears unlock and request
module swc_suspend_warmup #(
	parameter int POR_WARMUP_LEN = swc_pkg::POR_WARMUP_CKS,
	parameter int OSC_WARM_SHIFT = 0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic instr_step,
	input wire logic wake_irq,
	input wire logic reset_pin_n,
	input wire logic lowvolt_reset_req,
	input wire logic watchdog_reset_req,
	input wire logic osc_clk,
	input wire logic overload_event,
	input wire swc_pkg::swc_option_t option_in,
	output swc_pkg::swc_config_t config_out,
	output logic core_clk_en,
	output logic periph_clk_en,
	output logic osc_enable,
	output logic core_reset,
	output logic warmup_active,
	output logic wake_done,
	output logic baud_double,
	output logic serial_ctrl_func_sel,
	output logic watchdog_run,
	output logic clock_monitor_active,
	output logic overload_reset_req,
	output logic overload_irq_req
);
	import swc_pkg::*;

	function automatic swc_config_t decode_opt(input swc_option_t o);
		swc_config_t c;
		c.src_rc16 = (o.clock_source_option == CLK_SRC_RC16);
		c.src_external = (o.clock_source_option == CLK_SRC_XTAL);
		c.range_low = o.osc_range_option;
		c.high_speed = o.high_speed_option & ~o.osc_range_option;
		c.reset_pin_is_reset = ~o.reset_pin_option;
		c.lowvolt_reset_enable = o.lowvolt_reset_enable_option;
		c.lowvolt_level_low = o.lowvolt_level_option;
		c.watchdog_enable = o.watchdog_enable_option;
		c.watchdog_in_sleep = o.watchdog_in_sleep_option & o.watchdog_enable_option;
		c.warmup_length = o.warmup_length_option;
		c.overload_irq_mode = o.overload_action_option;
		c.monitor_off_in_warmup = o.clock_monitor_warmup_option;
		return c;
	endfunction

	// internal rc ignores the length option
	function automatic logic [CNT_W-1:0] osc_len(input swc_config_t c);
		int e;
		e = OSC_EXP_RC;
		if (c.src_external) begin
			case (c.warmup_length)
				2'h0: e = OSC_EXP_00;
				2'h1: e = OSC_EXP_01;
				2'h2: e = OSC_EXP_10;
				default: e = OSC_EXP_11;
			endcase
		end
		e = e - OSC_WARM_SHIFT;
		if (e < 0) begin
			e = 0;
		end
		return CNT_W'(1 << e);
	endfunction

	swc_state_t state;
	logic [CNT_W-1:0] cnt;
	logic osc_after;
	logic irq_wake;
	logic reset_seq;

	swc_option_t opt;
	logic opt_loaded;
	swc_config_t cfg;

	logic [3:0] sync_raw;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] filt;
	logic [3:0] filt_q;

	logic [CK_DIV_W-1:0] ck_div;
	logic ck_tick;

	logic pin_rst_evt;
	logic lvr_evt;
	logic wdt_evt;
	logic osc_edge;
	logic reset_any;

	logic powerdown_request;
	logic idle_request;
	logic [1:0] general_sw_flags;
	logic [7:0] suspend_unlock;
	logic armed;
	logic clear_pending;

	logic pc_wr;
	logic su_wr;
	logic step;
	logic req_bits;
	logic accept;
	logic pwr_done;
	logic osc_done;
	logic seq_done;
	logic irq_exit;

	// before the latch the raw option pins give the live view
	assign cfg = decode_opt(opt_loaded ? opt : option_in);
	assign config_out = cfg;

	// pins and the oscillator are asynchronous to clk
	assign sync_raw = {osc_clk, watchdog_reset_req, lowvolt_reset_req, reset_pin_n};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					sync1[gi] <= SYNC_RESET[gi];
					sync2[gi] <= SYNC_RESET[gi];
					sync3[gi] <= SYNC_RESET[gi];
					filt[gi] <= SYNC_RESET[gi];
					filt_q[gi] <= SYNC_RESET[gi];
				end else begin
					sync1[gi] <= sync_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi]) begin
						filt[gi] <= sync3[gi];
					end
					filt_q[gi] <= filt[gi];
				end
			end
		end
	endgenerate

	assign pin_rst_evt = filt_q[0] & ~filt[0] & cfg.reset_pin_is_reset;
	assign lvr_evt = ~filt_q[1] & filt[1] & cfg.lowvolt_reset_enable;
	assign wdt_evt = ~filt_q[2] & filt[2] & cfg.watchdog_enable;
	assign osc_edge = ~filt_q[3] & filt[3];
	assign reset_any = pin_rst_evt | lvr_evt | wdt_evt;

	// count clock stands in for the 2MHz rc, independent of osc_clk
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ck_div <= '0;
		end else if (ck_div == CK_DIV_W'(CK_DIV - 1)) begin
			ck_div <= '0;
		end else begin
			ck_div <= ck_div + 1'b1;
		end
	end

	assign ck_tick = (ck_div == CK_DIV_W'(CK_DIV - 1));

	assign pc_wr = reg_wr & (reg_addr == ADDR_POWER_CONTROL);
	assign su_wr = reg_wr & (reg_addr == ADDR_SUSPEND_UNLOCK);
	// a read or an unrelated instruction also closes the key window
	assign step = reg_wr | reg_rd | instr_step;
	assign req_bits = reg_wdata[PC_PD_BIT] | reg_wdata[PC_IDLE_BIT];
	// the request write must be the instruction right after the key
	assign accept = pc_wr & req_bits & armed & (state == ST_RUN);

	assign pwr_done = (state == ST_PWR) & ck_tick & (cnt <= CNT_W'(1));
	assign osc_done = (state == ST_OSC) & osc_edge & (cnt <= CNT_W'(1));
	assign seq_done = (pwr_done & ~osc_after) | osc_done;
	assign irq_exit = ~reset_any & ((seq_done & irq_wake) | ((state == ST_IDLE) & wake_irq));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_PWR;
			cnt <= CNT_W'(POR_WARMUP_LEN);
			osc_after <= 1'b1;
			irq_wake <= 1'b0;
			reset_seq <= 1'b1;
		end else if (reset_any) begin
			state <= ST_PWR;
			reset_seq <= 1'b1;
			irq_wake <= 1'b0;
			// a short power warm-up only for pin or watchdog out of power-down
			if ((state == ST_PDOWN) & ~lvr_evt) begin
				cnt <= CNT_W'(PD_RESET_WARMUP_CKS);
				osc_after <= wdt_evt;
			end else begin
				cnt <= CNT_W'(POR_WARMUP_LEN);
				osc_after <= 1'b1;
			end
		end else begin
			case (state)
				ST_PWR: begin
					if (pwr_done) begin
						if (osc_after) begin
							state <= ST_OSC;
							cnt <= osc_len(cfg);
						end else begin
							state <= ST_RUN;
							reset_seq <= 1'b0;
							irq_wake <= 1'b0;
						end
					end else if (ck_tick) begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_OSC: begin
					if (osc_done) begin
						state <= ST_RUN;
						reset_seq <= 1'b0;
						irq_wake <= 1'b0;
					end else if (osc_edge) begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_RUN: begin
					if (accept & reg_wdata[PC_PD_BIT]) begin
						state <= ST_PDOWN;
					end else if (accept) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (wake_irq) begin
						state <= ST_RUN;
					end
				end
				ST_PDOWN: begin
					if (wake_irq) begin
						state <= ST_PWR;
						cnt <= CNT_W'(IRQ_WAKE_WARMUP_CKS);
						osc_after <= 1'b1;
						irq_wake <= 1'b1;
					end
				end
				default: begin
					state <= ST_PWR;
					cnt <= CNT_W'(POR_WARMUP_LEN);
					osc_after <= 1'b1;
					reset_seq <= 1'b1;
				end
			endcase
		end
	end

	// only power-on reloads options; later resets keep them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			opt <= OPTION_DEFAULT;
			opt_loaded <= 1'b0;
		end else if (~opt_loaded & (state == ST_PWR)) begin
			opt <= option_in;
			opt_loaded <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst | reset_any) begin
			baud_double <= POWER_CONTROL_RESET[PC_BAUD_DOUBLE_BIT];
			serial_ctrl_func_sel <= POWER_CONTROL_RESET[PC_SERIAL_CTRL_FUNC_SEL_BIT];
			general_sw_flags <= POWER_CONTROL_RESET[PC_GF_HI:PC_GF_LO];
		end else if (pc_wr) begin
			baud_double <= reg_wdata[PC_BAUD_DOUBLE_BIT];
			serial_ctrl_func_sel <= reg_wdata[PC_SERIAL_CTRL_FUNC_SEL_BIT];
			general_sw_flags <= reg_wdata[PC_GF_HI:PC_GF_LO];
		end
	end

	// a fresh write wins over the irq_exit and clear_pending clears in the same cycle, but not over a reset
	always_ff @(posedge clk) begin
		if (sys_rst | reset_any) begin
			powerdown_request <= POWER_CONTROL_RESET[PC_PD_BIT];
			idle_request <= POWER_CONTROL_RESET[PC_IDLE_BIT];
			clear_pending <= 1'b0;
		end else begin
			clear_pending <= pc_wr & req_bits & ~accept;
			if (pc_wr) begin
				powerdown_request <= reg_wdata[PC_PD_BIT];
				idle_request <= reg_wdata[PC_IDLE_BIT];
			end else if (irq_exit | clear_pending) begin
				powerdown_request <= 1'b0;
				idle_request <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst | reset_any) begin
			suspend_unlock <= SUSPEND_UNLOCK_RESET;
			armed <= 1'b0;
		end else if (su_wr) begin
			suspend_unlock <= reg_wdata;
			armed <= (reg_wdata == UNLOCK_KEY);
		end else if (irq_exit) begin
			suspend_unlock <= '0;
			armed <= 1'b0;
		end else if (step & armed) begin
			armed <= 1'b0;
			if (~accept) begin
				suspend_unlock <= '0;
			end
		end
	end

	// unused bits 5:4 of power_control read as zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (reg_rd & (reg_addr == ADDR_POWER_CONTROL)) begin
			reg_rdata <= {baud_double, serial_ctrl_func_sel, 2'b00, general_sw_flags,
				powerdown_request, idle_request};
		end else if (reg_rd & (reg_addr == ADDR_SUSPEND_UNLOCK)) begin
			reg_rdata <= suspend_unlock;
		end else begin
			reg_rdata <= '0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wake_done <= 1'b0;
			overload_reset_req <= 1'b0;
			overload_irq_req <= 1'b0;
		end else begin
			wake_done <= irq_exit;
			overload_reset_req <= overload_event & ~cfg.overload_irq_mode;
			overload_irq_req <= overload_event & cfg.overload_irq_mode;
		end
	end

	assign core_clk_en = (state == ST_RUN);
	assign periph_clk_en = (state == ST_RUN) | (state == ST_IDLE);
	assign osc_enable = (state != ST_PDOWN);
	assign core_reset = reset_seq;
	assign warmup_active = (state == ST_PWR) | (state == ST_OSC);
	assign clock_monitor_active = ~(warmup_active & cfg.monitor_off_in_warmup);
	assign watchdog_run = cfg.watchdog_enable & ((state != ST_PDOWN) | cfg.watchdog_in_sleep);

endmodule

// ===== verification/swc_suspend_warmup_sva.sv
// concurrent checks on the ports of the suspend and warm-up controller
`timescale 1ns/100ps
module swc_suspend_warmup_sva
	import swc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic instr_step,
	input wire logic wake_irq,
	input wire logic overload_event,
	input wire swc_pkg::swc_config_t config_out,
	input wire logic core_clk_en,
	input wire logic periph_clk_en,
	input wire logic osc_enable,
	input wire logic warmup_active,
	input wire logic wake_done,
	input wire logic baud_double,
	input wire logic serial_ctrl_func_sel,
	input wire logic watchdog_run,
	input wire logic clock_monitor_active,
	input wire logic overload_reset_req,
	input wire logic overload_irq_req
);
	logic key_q;
	logic [7:0] wd_q;
	logic pc_wr;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	assign pc_wr = reg_wr && reg_addr == ADDR_POWER_CONTROL;
	// unlock key seen at the last instruction boundary; idle cycles keep it
	always_ff @(posedge clk) begin
		if (sys_rst || !core_clk_en) begin
			key_q <= 1'b0;
		end else if (reg_wr || reg_rd || instr_step) begin
			key_q <= reg_wr && reg_addr == ADDR_SUSPEND_UNLOCK && reg_wdata == UNLOCK_KEY;
		end
	end
	always_ff @(posedge clk) begin
		wd_q <= reg_wdata;
	end
	a_core_held_warmup: assert property (warmup_active |-> !core_clk_en)
		else $error("core clock runs during warm-up");
	a_broken_stays_awake: assert property (pc_wr && reg_wdata[1:0] != 2'h0 && core_clk_en && !key_q
		|=> core_clk_en [*3])
		else $error("suspend entered without unlock");
	a_idle_entry: assert property (pc_wr && reg_wdata[1:0] == 2'h1 && core_clk_en && key_q
		|=> !core_clk_en && periph_clk_en && osc_enable)
		else $error("idle not entered");
	a_pd_wins: assert property (pc_wr && reg_wdata[1] && core_clk_en && key_q
		|=> !core_clk_en && !periph_clk_en && !osc_enable)
		else $error("power-down not entered");
	a_idle_wake: assert property (periph_clk_en && !core_clk_en && wake_irq |=> core_clk_en && wake_done)
		else $error("idle wake late");
	a_serial_bits: assert property (pc_wr |=> baud_double == wd_q[PC_BAUD_DOUBLE_BIT]
		&& serial_ctrl_func_sel == wd_q[PC_SERIAL_CTRL_FUNC_SEL_BIT])
		else $error("serial bits not stored");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_ovl_irq: assert property (overload_event && config_out.overload_irq_mode
		|=> overload_irq_req && !overload_reset_req)
		else $error("overload interrupt missing");
	a_ovl_reset: assert property (overload_event && !config_out.overload_irq_mode
		|=> overload_reset_req && !overload_irq_req)
		else $error("overload reset missing");
	a_wdt_run: assert property (watchdog_run == (config_out.watchdog_enable
		&& (osc_enable || config_out.watchdog_in_sleep)))
		else $error("watchdog run wrong");
	a_monitor_gate: assert property (clock_monitor_active == !(warmup_active
		&& config_out.monitor_off_in_warmup))
		else $error("clock monitor gating wrong");
endmodule
bind swc_suspend_warmup swc_suspend_warmup_sva u_sva (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .instr_step, .wake_irq, .overload_event, .config_out, .core_clk_en, .periph_clk_en, .osc_enable,
	.warmup_active, .wake_done, .baud_double, .serial_ctrl_func_sel, .watchdog_run, .clock_monitor_active,
	.overload_reset_req, .overload_irq_req);

// ===== verification/tb.sv
// self-checking bench for the suspend and warm-up controller
`timescale 1ns/100ps
module tb;
	import swc_pkg::*;
	logic clk, sys_rst, reg_wr, reg_rd, instr_step, wake_irq, reset_pin_n, lowvolt_reset_req;
	logic watchdog_reset_req, osc_clk, overload_event;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	swc_option_t option_in;
	swc_config_t config_out;
	logic core_clk_en, periph_clk_en, osc_enable, core_reset, warmup_active, wake_done, baud_double;
	logic serial_ctrl_func_sel, watchdog_run, clock_monitor_active, overload_reset_req, overload_irq_req;
	int error_cnt, checks_done, n;
	// short counts keep each boot near two thousand cycles
	swc_suspend_warmup #(.POR_WARMUP_LEN(20), .OSC_WARM_SHIFT(4)) uut (.clk, .sys_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .instr_step, .wake_irq, .reset_pin_n, .lowvolt_reset_req,
		.watchdog_reset_req, .osc_clk, .overload_event, .option_in, .config_out, .core_clk_en, .periph_clk_en,
		.osc_enable, .core_reset, .warmup_active, .wake_done, .baud_double, .serial_ctrl_func_sel,
		.watchdog_run, .clock_monitor_active, .overload_reset_req, .overload_irq_req);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// oscillator at a quarter of clk, slow enough for the agree filter; stops in power-down
	logic [1:0] osc_div = 2'h0;
	always @(posedge clk) begin
		osc_div <= osc_div + 2'h1;
		osc_clk <= (osc_enable === 1'b1) && osc_div[1];
	end
	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic w, input logic r, input logic s, input logic [7:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		instr_step <= s;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		op(1'b0, 1'b1, 1'b0, a, 8'h00);
		#1 chk(reg_rdata, e);
		op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic wait_run(input int lim);
		n = 0;
		while (core_clk_en !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic pulse_wake();
		wake_irq <= 1'b1;
		@(posedge clk);
		wake_irq <= 1'b0;
		#1;
	endtask
	function automatic swc_config_t dec(swc_option_t o);
		dec = '{o.clock_source_option == CLK_SRC_RC16, o.clock_source_option == CLK_SRC_XTAL, o.osc_range_option,
			o.high_speed_option & ~o.osc_range_option, ~o.reset_pin_option, o.lowvolt_reset_enable_option,
			o.lowvolt_level_option, o.watchdog_enable_option, o.watchdog_in_sleep_option & o.watchdog_enable_option,
			o.warmup_length_option, o.overload_action_option, o.clock_monitor_warmup_option};
	endfunction
	task automatic boot(input swc_option_t o);
		option_in <= o;
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1 chk({core_clk_en, core_reset, warmup_active}, 16'h3);
		wait_run(20000);
		chk(16'(n >= 1900), 16'h1);
		// raw options moved after the latch must not show through
		option_in <= ~o;
		rd(ADDR_POWER_CONTROL, POWER_CONTROL_RESET);
		rd(ADDR_SUSPEND_UNLOCK, SUSPEND_UNLOCK_RESET);
		chk(config_out, dec(o));
		overload_event <= 1'b1;
		@(posedge clk);
		overload_event <= 1'b0;
		#1 chk({overload_irq_req, overload_reset_req}, {o.overload_action_option, ~o.overload_action_option});
	endtask
	initial begin
		{reg_wr, reg_rd, instr_step, wake_irq, lowvolt_reset_req, watchdog_reset_req, overload_event} = '0;
		{reg_addr, reg_wdata, error_cnt, checks_done} = '0;
		reset_pin_n = 1'b1;
		sys_rst = 1'b1;
		option_in = OPTION_DEFAULT;
		boot(OPTION_DEFAULT);
		op(1'b1, 1'b0, 1'b0, ADDR_POWER_CONTROL, 8'hFC);
		rd(ADDR_POWER_CONTROL, 8'hCC);
		chk({baud_double, serial_ctrl_func_sel}, 16'h3);
		op(1'b1, 1'b0, 1'b0, ADDR_SUSPEND_UNLOCK, 8'hA5);
		rd(ADDR_SUSPEND_UNLOCK, 8'hA5);
		rd(8'h80, 8'h00);
		// key followed by another instruction, then a request with no key
		op(1'b1, 1'b0, 1'b0, ADDR_SUSPEND_UNLOCK, UNLOCK_KEY);
		op(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		rd(ADDR_SUSPEND_UNLOCK, 8'h00);
		op(1'b1, 1'b0, 1'b0, ADDR_POWER_CONTROL, 8'hCD);
		op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		rd(ADDR_POWER_CONTROL, 8'hCC);
		chk(core_clk_en, 16'h1);
		op(1'b1, 1'b0, 1'b0, ADDR_SUSPEND_UNLOCK, UNLOCK_KEY);
		op(1'b1, 1'b0, 1'b0, ADDR_POWER_CONTROL, 8'hCD);
		op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		#1 chk({core_clk_en, periph_clk_en}, 16'h1);
		pulse_wake();
		chk({core_clk_en, wake_done}, 16'h3);
		rd(ADDR_POWER_CONTROL, 8'hCC);
		rd(ADDR_SUSPEND_UNLOCK, 8'h00);
		op(1'b1, 1'b0, 1'b0, ADDR_SUSPEND_UNLOCK, UNLOCK_KEY);
		op(1'b1, 1'b0, 1'b0, ADDR_POWER_CONTROL, 8'hCF);
		op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		#1 chk({core_clk_en, periph_clk_en, osc_enable}, 16'h0);
		pulse_wake();
		wait_run(20000);
		chk(16'(n >= 6300), 16'h1);
		op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		rd(ADDR_POWER_CONTROL, 8'hCC);
		rd(ADDR_SUSPEND_UNLOCK, 8'h00);
		boot('{CLK_SRC_RC16, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 1'b0, 1'b1});
		boot('{CLK_SRC_XTAL, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3, 1'b0, 1'b0});
		// pin reset in run: registers clear, latched options stay
		op(1'b1, 1'b0, 1'b0, ADDR_POWER_CONTROL, 8'hCC);
		rd(ADDR_POWER_CONTROL, 8'hCC);
		reset_pin_n <= 1'b0;
		repeat (10) @(posedge clk);
		reset_pin_n <= 1'b1;
		#1 chk({core_clk_en, core_reset}, 16'h1);
		wait_run(20000);
		chk(16'(n >= 1900), 16'h1);
		rd(ADDR_POWER_CONTROL, POWER_CONTROL_RESET);
		chk(config_out, dec(~option_in));
		conclude();
	end
endmodule
